// file: core/bscd_burst_sram.sv
// Cycle decoder of a two-word burst SRAM with separate read and write ports
`timescale 1ns/1ps
module bscd_burst_sram (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_kpos,
  input wire logic i_kneg,
  input wire logic i_cpos,
  input wire logic i_cneg,
  input wire logic [bscd_pkg::ADDR_W-1:0] i_addr,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic [bscd_pkg::LANES-1:0] byte_lane_write_enable_n,
  input wire logic [bscd_pkg::DATA_W-1:0] i_wdata,
  input wire logic pll_bypass_strap_n,
  input wire logic i_wide,
  output logic [bscd_pkg::DATA_W-1:0] o_rdata,
  output logic o_rdata_oe
);
  localparam int AW = bscd_pkg::ADDR_W;
  localparam int DW = bscd_pkg::DATA_W;
  localparam int NL = bscd_pkg::LANES;

  // ----------------------------------------
  // Lane decode
  // ----------------------------------------
  // Narrow parts only own lanes 0 and 1; upper enables are ignored
  function automatic logic [NL-1:0] lane_sel(input logic [NL-1:0] en_n, input logic wide);
    lane_sel = wide ? ~en_n : {2'b00, ~en_n[1:0]};
  endfunction

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  logic [bscd_pkg::SYNC_W-1:0] pin_bus;
  logic [bscd_pkg::SYNC_W-1:0] sync1;
  logic [bscd_pkg::SYNC_W-1:0] sync2;
  logic [3:0] clk_d;

  // All pins travel together so data stays aligned with the clock edges
  assign pin_bus = {i_wide, pll_bypass_strap_n, i_addr, i_wdata, byte_lane_write_enable_n,
                    write_port_select_n, read_port_select_n, i_cneg, i_cpos, i_kneg, i_kpos};

  // Stage one feeds stage two only; edges are found from stage two onward
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      sync1 <= '0;
      sync2 <= '0;
      clk_d <= 4'h0;
    end
    else
    begin
      sync1 <= pin_bus;
      sync2 <= sync1;
      clk_d <= sync2[3:0];
    end
  end

  // ----------------------------------------
  // Power-up straps
  // ----------------------------------------
  logic [1:0] strap_cnt;
  logic strap_done;
  logic single_mode;
  logic lat_one;

  // The synchroniser must fill with real pin levels before a strap is caught
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      strap_cnt <= bscd_pkg::STRAP_RST;
      strap_done <= 1'b0;
      single_mode <= 1'b0;
      lat_one <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == bscd_pkg::STRAP_WAIT)
      begin
        strap_done <= 1'b1;
        single_mode <= sync2[bscd_pkg::P_CPOS] & sync2[bscd_pkg::P_CNEG]; // R18
        lat_one <= ~sync2[bscd_pkg::P_BYP]; // R16
      end
    end
  end

  // ----------------------------------------
  // Edge detection and sampled controls
  // ----------------------------------------
  logic kpos_rise;
  logic kneg_rise;
  logic opos_rise;
  logic oneg_rise;
  logic rsel_n;
  logic wsel_n;
  logic wide_s;
  logic [NL-1:0] lane_n;
  logic [DW-1:0] wdata_s;
  logic [AW-1:0] addr_s;

  // No edge, no action: stopped clocks leave every state alone
  assign kpos_rise = strap_done & sync2[bscd_pkg::P_KPOS] & ~clk_d[0]; // R15
  assign kneg_rise = strap_done & sync2[bscd_pkg::P_KNEG] & ~clk_d[1]; // R15
  // In single clock mode the input pair also times the outputs
  assign opos_rise = single_mode ? kpos_rise : strap_done & sync2[bscd_pkg::P_CPOS] & ~clk_d[2]; // R5
  assign oneg_rise = single_mode ? kneg_rise : strap_done & sync2[bscd_pkg::P_CNEG] & ~clk_d[3]; // R5
  assign rsel_n = sync2[bscd_pkg::P_RSEL];
  assign wsel_n = sync2[bscd_pkg::P_WSEL];
  assign wide_s = sync2[bscd_pkg::P_WIDE];
  assign lane_n = sync2[bscd_pkg::P_LANE +: NL];
  assign wdata_s = sync2[bscd_pkg::P_DATA +: DW];
  assign addr_s = sync2[bscd_pkg::P_ADDR +: AW];

  // ----------------------------------------
  // Write port
  // ----------------------------------------
  logic wr_start;
  logic wr_pend;
  logic [AW-1:0] wr_base;
  logic wr_en;
  logic [bscd_pkg::WADDR_W-1:0] wr_addr;
  logic [NL-1:0] wr_lane;

  // Selects are looked at only on the positive input clock rise
  assign wr_start = kpos_rise & ~wsel_n; // R1 R14
  assign wr_en = wr_start | (kneg_rise & wr_pend); // R1 R5
  assign wr_addr = wr_start ? {addr_s, 1'b0} : {wr_base, 1'b1}; // R3
  // Mask comes from the same edge as the word it guards
  assign wr_lane = wr_en ? lane_sel(lane_n, wide_s) : '0; // R7 R8 R9 R10 R11 R12 R13

  // Second word waits for the following negative input clock rise
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      wr_pend <= 1'b0;
      wr_base <= '0;
    end
    else if (wr_start)
    begin
      wr_pend <= 1'b1; // R1
      wr_base <= addr_s; // R3
    end
    else if (kneg_rise)
    begin
      wr_pend <= 1'b0;
    end
  end

  // ----------------------------------------
  // Read pipeline
  // ----------------------------------------
  logic rq0_v;
  logic rq1_v;
  logic rq2_v;
  logic [AW-1:0] rq0_a;
  logic [AW-1:0] rq1_a;
  logic [AW-1:0] rq2_a;
  logic rd_start;

  assign rd_start = kpos_rise & ~rsel_n; // R2 R14

  // Bursts move one stage per positive input clock so reads may run back to back
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      rq0_v <= 1'b0;
      rq1_v <= 1'b0;
      rq2_v <= 1'b0;
      rq0_a <= '0;
      rq1_a <= '0;
      rq2_a <= '0;
    end
    else if (kpos_rise)
    begin
      rq0_v <= rd_start;
      rq0_a <= addr_s; // R3
      rq1_v <= rq0_v;
      rq1_a <= rq0_a;
      rq2_v <= rq1_v;
      rq2_a <= rq1_a;
    end
  end

  // ----------------------------------------
  // Output slot selection
  // ----------------------------------------
  logic pos_v;
  logic [AW-1:0] pos_a;
  logic issue;
  logic rd_v;
  logic [bscd_pkg::WADDR_W-1:0] rd_addr;

  // An output rise that meets an input rise reads the stage before the shift
  assign pos_v = lat_one ? (kpos_rise ? rq0_v : rq1_v) : (kpos_rise ? rq1_v : rq2_v); // R2 R16
  assign pos_a = lat_one ? (kpos_rise ? rq0_a : rq1_a) : (kpos_rise ? rq1_a : rq2_a); // R2 R16
  assign issue = opos_rise | oneg_rise;
  // Long latency: word 0 on negative rise, word 1 on positive; short swaps them
  assign rd_v = opos_rise ? pos_v : rq1_v; // R2 R17
  assign rd_addr = opos_rise ? {pos_a, ~lat_one} : {rq1_a, lat_one}; // R3 R16

  // ----------------------------------------
  // Word store
  // ----------------------------------------
  logic [DW-1:0] ram_q;

  bscd_word_ram u_ram (
    .i_mclk(i_mclk),
    .i_lane_we(wr_lane),
    .i_waddr(wr_addr),
    .i_wdata(wdata_s),
    .i_raddr(rd_addr),
    .o_rdata(ram_q)
  );

  // ----------------------------------------
  // Output register
  // ----------------------------------------
  logic ld;
  logic ld_v;
  logic [DW-1:0] q_mask;

  // Narrow parts never show the upper lanes
  assign q_mask = wide_s ? ram_q : {{(DW - bscd_pkg::NARROW_W){1'b0}}, ram_q[bscd_pkg::NARROW_W-1:0]};

  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      ld <= 1'b0;
      ld_v <= 1'b0;
    end
    else
    begin
      ld <= issue;
      ld_v <= rd_v;
    end
  end

  // Store read takes one clock, so outputs update two clocks after the edge
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_rdata <= '0;
      o_rdata_oe <= 1'b0; // R4
    end
    else if (ld)
    begin
      o_rdata_oe <= ld_v; // R17 R14
      o_rdata <= ld_v ? q_mask : '0; // R2
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  localparam int RD_MAX = 40;

  property p_wr_first;
    @(posedge i_mclk) disable iff (i_reset)
    wr_start |-> wr_en && !wr_addr[0] && wr_addr[AW:1] == addr_s;
  endproperty
  a_wr_first: assert property (p_wr_first) else $error("write burst first word misplaced"); // R1

  property p_wr_second;
    @(posedge i_mclk) disable iff (i_reset)
    (kneg_rise && wr_pend && !wr_start) |-> wr_en && wr_addr == {wr_base, 1'b1};
  endproperty
  a_wr_second: assert property (p_wr_second) else $error("second write word not at base+1"); // R3

  property p_no_edge_no_write;
    @(posedge i_mclk) disable iff (i_reset)
    !(kpos_rise || kneg_rise) |-> wr_lane == '0;
  endproperty
  a_no_edge_no_write: assert property (p_no_edge_no_write) else $error("write without clock edge"); // R15

  property p_lane_map;
    @(posedge i_mclk) disable iff (i_reset)
    (wr_en && wide_s) |-> wr_lane == ~lane_n;
  endproperty
  a_lane_map: assert property (p_lane_map) else $error("wide lane enable mismatch"); // R12

  property p_narrow_lanes;
    @(posedge i_mclk) disable iff (i_reset)
    (wr_en && !wide_s) |-> wr_lane[3:2] == 2'b00 && wr_lane[1:0] == ~lane_n[1:0];
  endproperty
  a_narrow_lanes: assert property (p_narrow_lanes) else $error("narrow lane enable mismatch"); // R8

  property p_all_masked;
    @(posedge i_mclk) disable iff (i_reset)
    (wr_en && &lane_n) |-> wr_lane == '0;
  endproperty
  a_all_masked: assert property (p_all_masked) else $error("masked word was written"); // R10

  property p_quiet_after_reset;
    @(posedge i_mclk) disable iff (i_reset)
    !strap_done |-> !o_rdata_oe;
  endproperty
  a_quiet_after_reset: assert property (p_quiet_after_reset) else $error("outputs driven at power-up"); // R4

  property p_read_appears;
    @(posedge i_mclk) disable iff (i_reset)
    (rd_start && !o_rdata_oe) |-> ##[2:RD_MAX] o_rdata_oe;
  endproperty
  a_read_appears: assert property (p_read_appears) else $error("read data never driven"); // R2

  property p_float_after;
    @(posedge i_mclk) disable iff (i_reset)
    (issue && !rd_v) |-> ##2 !o_rdata_oe;
  endproperty
  a_float_after: assert property (p_float_after) else $error("outputs not released"); // R17

  property p_hold_quiet;
    @(posedge i_mclk) disable iff (i_reset)
    !ld |=> $stable(o_rdata) && $stable(o_rdata_oe);
  endproperty
  a_hold_quiet: assert property (p_hold_quiet) else $error("outputs moved without edge"); // R15

  c_write: cover property (@(posedge i_mclk) disable iff (i_reset) wr_start ##[1:RD_MAX] wr_en);
  c_read: cover property (@(posedge i_mclk) disable iff (i_reset) rd_start ##[2:RD_MAX] o_rdata_oe);
  c_partial: cover property (@(posedge i_mclk) disable iff (i_reset) wr_en && wr_lane == 4'h1);
  c_short_lat: cover property (@(posedge i_mclk) disable iff (i_reset) lat_one && o_rdata_oe);
endmodule

// file: core/bscd_pkg.sv
// Constants shared by the burst SRAM cycle decoder and its word store
// What this block does
// (R1) Write starts on positive input clock rise with write select low; words at A+0, A+1.
// (R2) Read started in cycle t drives first word at t+1.5, second at t+2.
// (R3) Captured address is the burst base; second word goes to base plus one.
// (R4) After power-up both ports are idle and read outputs are not driven.
// (R5) Write data taken on input clock rises; read data on output clock rises.
// (R6) Stopped clocks should rest equal inputs and high outputs; controller's choice.
// (R7) Narrow width, both lane enables low: all 18 bits of the word written.
// (R8) Narrow width, only lane 0 enabled: bits 8:0 written, 17:9 kept.
// (R9) Narrow width, only lane 1 enabled: bits 17:9 written, 8:0 kept.
// (R10) All lane enables high: the word in the array is left untouched.
// (R11) Wide width, all four lane enables low: all 36 bits written.
// (R12) Wide width, each enable gates one 9-bit lane; disabled lanes kept.
// (R13) Lane mask is sampled per word and applies to that word alone.
// (R14) Both selects high: nothing starts; outputs float once pending bursts end.
// (R15) With input clocks stopped, state and outputs hold; nothing starts.
// (R16) Bypass strap low selects one-cycle read latency instead of one and a half.
// (R17) After the last burst word, outputs float after the next output clock rise.
// (R18) Both output clocks high at power-on select single clock mode, fixed.
package bscd_pkg;
  localparam int DATA_W = 36;
  localparam int NARROW_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int ADDR_W = 8;
  localparam int WADDR_W = ADDR_W + 1;
  // Positions inside the bundle of pin inputs that pass the synchroniser
  localparam int P_KPOS = 0;
  localparam int P_KNEG = 1;
  localparam int P_CPOS = 2;
  localparam int P_CNEG = 3;
  localparam int P_RSEL = 4;
  localparam int P_WSEL = 5;
  localparam int P_LANE = 6;
  localparam int P_DATA = P_LANE + LANES;
  localparam int P_ADDR = P_DATA + DATA_W;
  localparam int P_BYP = P_ADDR + ADDR_W;
  localparam int P_WIDE = P_BYP + 1;
  localparam int SYNC_W = P_WIDE + 1;
  // Clocks to wait after reset before the straps are trusted
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic [1:0] STRAP_RST = 2'h0;
  // Timing of the local clock and of the link clocks
  localparam int CLK_NS = 50;
  localparam int LINK_NS = 400;
  localparam int LINK_CYC = LINK_NS / CLK_NS;
endpackage

// file: core/bscd_word_ram.sv
// Burst word store with per-lane write enables and a registered read port
`timescale 1ns/1ps
module bscd_word_ram (
  input wire logic i_mclk,
  input wire logic [bscd_pkg::LANES-1:0] i_lane_we,
  input wire logic [bscd_pkg::WADDR_W-1:0] i_waddr,
  input wire logic [bscd_pkg::DATA_W-1:0] i_wdata,
  input wire logic [bscd_pkg::WADDR_W-1:0] i_raddr,
  output logic [bscd_pkg::DATA_W-1:0] o_rdata
);
  localparam int DEPTH = 1 << bscd_pkg::WADDR_W;
  localparam int LW = bscd_pkg::LANE_W;

  // ----------------------------------------
  // One array per lane, disabled lanes keep their bits
  // ----------------------------------------
  // Separate arrays keep every lane's store owned by exactly one process
  genvar g;
  generate
    for (g = 0; g < bscd_pkg::LANES; g++)
    begin : g_lane
      logic [LW-1:0] mem [DEPTH];

      always_ff @(posedge i_mclk)
      begin
        if (i_lane_we[g])
        begin
          mem[i_waddr] <= i_wdata[g*LW +: LW];
        end
      end

      // Read data always from a flop, one clock after the address
      always_ff @(posedge i_mclk)
      begin
        o_rdata[g*LW +: LW] <= mem[i_raddr];
      end
    end
  endgenerate
endmodule

// file: tb/bscd_burst_sram_tb.sv
// Self-checking bench: writes and reads bursts in three strap modes against a word model
`timescale 1ns/1ps
module bscd_burst_sram_tb;
  logic i_mclk, i_reset, strap_n, wide, single, rd, wr;
  wire logic kp, kn, cp, cn, rs_n, ws_n;
  wire logic [7:0] addr;
  wire logic [3:0] lane_n;
  wire logic [35:0] wd;
  wire logic [2:0] ph;
  wire logic [15:0] cy;
  logic [35:0] o_rdata;
  logic o_rdata_oe;
  int err_total, checked, seed, cnum, s, a, last_rd, cs;
  logic [35:0] mem [0:15];
  logic [35:0] exp_v [0:511];
  logic exp_on [0:511];

  bscd_ctl_model ctl (.i_mclk(i_mclk), .i_single(single), .o_kpos(kp), .o_kneg(kn),
    .o_cpos(cp), .o_cneg(cn), .o_addr(addr), .o_rsel_n(rs_n), .o_wsel_n(ws_n),
    .o_lane_n(lane_n), .o_wdata(wd), .o_ph(ph), .o_cy(cy));
  bscd_burst_sram DUT (.i_mclk(i_mclk), .i_reset(i_reset), .i_kpos(kp), .i_kneg(kn),
    .i_cpos(cp), .i_cneg(cn), .i_addr(addr), .read_port_select_n(rs_n),
    .write_port_select_n(ws_n), .byte_lane_write_enable_n(lane_n), .i_wdata(wd),
    .pll_bypass_strap_n(strap_n), .i_wide(wide), .o_rdata(o_rdata), .o_rdata_oe(o_rdata_oe));

  initial
  begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  task automatic chk(input logic [35:0] got, input logic [35:0] want);
    checked++;
    if (got !== want)
    begin
      err_total++;
      $display("[FAIL] %0t read port got %h expected %h", $time, got, want);
    end
  endtask

  // Word as the read port shows it: narrow parts drive zeros above bit 17
  function automatic logic [35:0] shown(input int idx);
    return wide ? mem[idx] : {18'h0, mem[idx][17:0]};
  endfunction

  // Lane-masked update of the model; only two lanes exist in the narrow part
  task automatic put(input int idx, input logic [35:0] d, input logic [3:0] m);
    for (int i = 0; i < (wide ? 4 : 2); i++)
      if (!m[i])
        mem[idx][i*9 +: 9] = d[i*9 +: 9];
  endtask

  // One link cycle: update the model, book the expected read slots, drive the pins
  task automatic step(input bit r, input bit w, input int ad, input logic [35:0] d0,
    input logic [35:0] d1, input logic [3:0] m0, input logic [3:0] m1);
    cnum++;
    if (w)
    begin
      put(ad * 2, d0, m0);
      put(ad * 2 + 1, d1, m1);
    end
    if (r)
    begin
      // Short latency shows the first word half a cycle earlier
      s = (2 * cnum + (strap_n ? 4 : 3)) % 512;
      exp_v[s] = shown(ad * 2);
      exp_on[s] = 1'b1;
      exp_v[s + 1] = shown(ad * 2 + 1);
      exp_on[s + 1] = 1'b1;
    end
    ctl.cyc(!r, !w, ad[7:0], d0, d1, m0, m1);
  endtask

  // Look at the read port once per half cycle, inside the window where it must be steady
  always @(posedge i_mclk)
  begin
    if (!i_reset && (ph == 3'h3 || ph == 3'h7))
    begin
      cs = (2 * cy + (ph == 3'h7)) % 512;
      if (exp_on[cs])
      begin
        chk({35'h0, o_rdata_oe}, 36'h1);
        chk(o_rdata, exp_v[cs]);
      end
      else
      begin
        chk({35'h0, o_rdata_oe}, 36'h0);
        chk(o_rdata, 36'h0);
      end
      exp_on[cs] = 1'b0;
    end
  end

  task automatic run_phase(input bit w, input bit b, input bit sg);
    i_reset = 1'b1;
    {wide, strap_n, single} = {w, b, sg};
    for (int i = 0; i < 512; i++)
      exp_on[i] = 1'b0;
    repeat (10) @(posedge i_mclk);
    #2 i_reset = 1'b0;
    repeat (8) @(posedge i_mclk);
    chk({35'h0, o_rdata_oe}, 36'h0);
    for (int i = 0; i < 8; i++)
      step(0, 1, i, 36'({$random(seed), $random(seed)}),
        36'({$random(seed), $random(seed)}), 4'h0, 4'h0);
    // Lane 0 then lane 1 only, read right behind the write
    step(0, 1, 1, 36'h9_aaaa_5555, 36'h6_1234_5678, 4'he, 4'hd);
    step(1, 0, 1, 36'h0, 36'h0, 4'hf, 4'hf);
    // Upper lanes one word each, then a fully masked write
    step(0, 1, 2, 36'hf_0f0f_0f0f, 36'h1_2345_6789, 4'hb, 4'h7);
    step(0, 1, 3, 36'hf_ffff_ffff, 36'h0, 4'hf, 4'hf);
    step(1, 0, 2, 36'h0, 36'h0, 4'hf, 4'hf);
    step(1, 0, 3, 36'h0, 36'h0, 4'hf, 4'hf);
    // Burst 3 was just read, so the first random write must steer clear of it
    last_rd = 3;
    for (int n = 0; n < 40; n++)
    begin
      s = $random(seed) & 3;
      a = $random(seed) & 7;
      rd = (s == 2);
      wr = (s[0] == 1'b1);
      // A write right after a read of the same burst would race the array fetch
      if (wr && a == last_rd)
        a = a ^ 1;
      step(rd, wr, a, 36'({$random(seed), $random(seed)}), 36'({$random(seed), $random(seed)}),
        4'($random(seed)), 4'($random(seed)));
      last_rd = rd ? a : 99;
    end
    for (int n = 0; n < 4; n++)
      step(0, 0, 5, 36'h0, 36'h0, 4'h0, 4'h0);
    ctl.stop();
    repeat (20) @(posedge i_mclk);
    chk({35'h0, o_rdata_oe}, 36'h0);
    $display("Phase done: wide=%0d strap=%0d single=%0d errors=%0d", w, b, sg, err_total);
  endtask

  task automatic give_verdict();
    $display("Checks made %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    {i_reset, strap_n, wide, single} = 4'hc;
    {err_total, checked, cnum} = 0;
    seed = 32'h8996fa37;
    run_phase(1, 1, 0);
    run_phase(0, 0, 0);
    run_phase(1, 0, 1);
    give_verdict();
  end

  // Roughly 80 us of traffic is expected; give it ample margin
  initial
  begin
    #2000000;
    err_total++;
    give_verdict();
  end
endmodule

// file: tb/bscd_ctl_model.sv
// Memory controller model that drives the burst SRAM pins one clock cycle at a time
`timescale 1ns/1ps
module bscd_ctl_model (
  input wire logic i_mclk,
  input wire logic i_single,
  output logic o_kpos,
  output logic o_kneg,
  output wire logic o_cpos,
  output wire logic o_cneg,
  output logic [7:0] o_addr,
  output logic o_rsel_n,
  output logic o_wsel_n,
  output logic [3:0] o_lane_n,
  output logic [35:0] o_wdata,
  output logic [2:0] o_ph,
  output logic [15:0] o_cy
);
  logic c_lag_p;
  logic c_lag_n;
  // Output clocks lag the input pair by one local clock, or rest high as the mode strap
  assign o_cpos = i_single | c_lag_p;
  assign o_cneg = i_single | c_lag_n;
  // Quiet pins at power-on, clocks at rest
  initial
  begin
    {o_kpos, o_kneg, o_rsel_n, o_wsel_n} = 4'h3;
    {c_lag_p, c_lag_n} = 2'h0;
    o_addr = 8'h00;
    o_lane_n = 4'hf;
    o_wdata = 36'h0;
    o_ph = 3'h0;
    o_cy = 16'h0;
  end
  // One link cycle is eight local clocks; pins settle one clock before each rise, hold three after
  task automatic cyc(input logic rd_n, input logic wr_n, input logic [7:0] a,
    input logic [35:0] d0, input logic [35:0] d1, input logic [3:0] m0, input logic [3:0] m1);
    for (int k = 0; k < 8; k++)
    begin
      @(posedge i_mclk);
      #2;
      o_ph = k[2:0];
      if (k == 0)
      begin
        o_cy = o_cy + 16'h1;
        {o_rsel_n, o_wsel_n, o_addr, o_wdata, o_lane_n} = {rd_n, wr_n, a, d0, m0};
      end
      if (k == 1)
        {o_kpos, o_kneg} = 2'h2;
      if (k == 2)
        {c_lag_p, c_lag_n} = 2'h2;
      if (k == 6)
        {c_lag_p, c_lag_n} = 2'h1;
      if (k == 4)
      begin
        // Mask may change between the two data edges
        {o_rsel_n, o_wsel_n, o_addr, o_wdata, o_lane_n} = {2'h3, ~a, d1, m1};
      end
      if (k == 5)
        {o_kpos, o_kneg} = 2'h1;
    end
  endtask
  // Stop the clocks with equal input levels; data is inverted once so no stale value lingers
  task automatic stop();
    @(posedge i_mclk);
    #2;
    {o_kpos, o_kneg} = 2'h0;
    {c_lag_p, c_lag_n} = 2'h0;
    o_ph = 3'h0;
    o_wdata = ~o_wdata;
  endtask
endmodule
